// ---- test/gport_assertions.sv ----
// Port-level checks for the graphics port command register
`timescale 1ns/1ns
`default_nettype none
module gport_assertions (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        rst_n,
	// Register port
	input wire logic [7:0]  addr,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	// Operations and state
	input wire logic        pipe_op_valid,
	input wire logic        sba_op_valid,
	input wire logic        sync_op_valid,
	input wire logic        pipe_op_accept,
	input wire logic        sba_op_accept,
	input wire logic        sync_op_accept,
	input wire logic        mode_30,
	input wire logic        sba_active,
	input wire logic        fast_write_sel,
	input wire logic [2:0]  write_rate,
	input wire logic        calib_cycle_start
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	pipe_cause_a: assert property (pipe_op_accept |-> $past(pipe_op_valid))
		else $error("pipe accept without request");
	sba_cause_a: assert property (sba_op_accept |-> $past(sba_op_valid))
		else $error("sideband accept without request");
	sync_cause_a: assert property (sync_op_accept |-> $past(sync_op_valid))
		else $error("sync accept without request");
	reserved_zero_a: assert property ($past(rd) && $past(addr) == 8'ha8 |->
		rdata[31:13] == 19'h0 && rdata[7:6] == 2'h0) else $error("reserved bits set");
	above_4g_a: assert property ($past(rd) |-> !rdata[5])
		else $error("above 4G bit set");
	fast_1x_a: assert property (fast_write_sel && !mode_30 && $stable(mode_30)
		&& $stable(write_rate) |-> write_rate != 3'h1) else $error("fast write in 1X");
	sba_auto_a: assert property (mode_30 && $past(mode_30) |-> sba_active)
		else $error("sideband not forced in 3.0 mode");
	calib_gap_a: assert property (calib_cycle_start |=> !calib_cycle_start [*8])
		else $error("calibration pulses too close");
endmodule

bind graphics_port_command_reg gport_assertions chk_i (.mclk, .rst_n, .addr, .rd, .rdata,
	.pipe_op_valid, .sba_op_valid, .sync_op_valid, .pipe_op_accept, .sba_op_accept,
	.sync_op_accept, .mode_30, .sba_active, .fast_write_sel, .write_rate,
	.calib_cycle_start);
`default_nettype wire

// ---- test/gport_master_model.sv ----
// Graphics master model: operation pulses and 1X sideband busy level
`timescale 1ns/1ns
`default_nettype none
module gport_master_model (
	// Clock
	input  wire logic mclk,
	// Operations toward the port
	output var logic  pipe_op_valid,
	output var logic  sba_op_valid,
	output var logic  sync_op_valid,
	output var logic  sba_1x_busy
);
	initial begin
		{pipe_op_valid, sba_op_valid, sync_op_valid, sba_1x_busy} = 4'h0;
	end

	// Kind is {pipe, sideband, sync}; held until the sampling edge
	task automatic issue(input logic [2:0] kind);
		{pipe_op_valid, sba_op_valid, sync_op_valid} <= kind;
		@(posedge mclk);
		{pipe_op_valid, sba_op_valid, sync_op_valid} <= 3'h0;
	endtask

	// Busy spans a whole 1X sideband command
	task automatic busy(input logic on);
		sba_1x_busy <= on;
	endtask
endmodule
`default_nettype wire

// ---- test/graphics_port_command_reg_test.sv ----
// Self-checking bench for the graphics port command register
`timescale 1ns/1ns
`default_nettype none
module graphics_port_command_reg_test;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        power_good = 1'b1;
	logic        vref_cmp_30 = 1'b0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic        mode_30, pipe_op_valid, sba_op_valid, sync_op_valid, sba_1x_busy;
	logic        pipe_op_accept, sba_op_accept, sync_op_accept;
	logic        sba_active, fast_write_sel, calib_cycle_start;
	logic [2:0]  write_rate;
	int          bad_count = 0;
	int          comparisons = 0;
	int          cycles = 0;
	int          pulses = 0;

	always #5 mclk = ~mclk;

	graphics_port_command_reg #(.MS_CYCLES(10)) dut (.mclk, .rst_n, .addr, .wdata, .wr,
		.rd, .rdata, .power_good, .vref_cmp_30, .mode_30, .pipe_op_valid, .sba_op_valid,
		.sync_op_valid, .sba_1x_busy, .pipe_op_accept, .sba_op_accept, .sync_op_accept,
		.sba_active, .fast_write_sel, .write_rate, .calib_cycle_start);
	gport_master_model model (.mclk, .pipe_op_valid, .sba_op_valid, .sync_op_valid,
		.sba_1x_busy);

	task automatic end_sim();
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (calib_cycle_start === 1'b1)
			pulses++;
		if (cycles == 5000) begin
			bad_count++;
			end_sim();
		end
	end

	task automatic chk(input logic ok, input string m);
		comparisons++;
		if (!ok) begin
			bad_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	task automatic wr32(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic rd32(input logic [7:0] a, input logic [31:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 chk(rdata === e, "read data");
		@(posedge mclk);
	endtask

	// Expected accepts as {pipe, sideband, sync}
	task automatic op(input logic [2:0] kind, input logic [2:0] e);
		model.issue(kind);
		#1 chk({pipe_op_accept, sba_op_accept, sync_op_accept} === e, "accept");
		@(posedge mclk);
	endtask

	task automatic fw(input logic [31:0] d, input logic s);
		wr32(8'ha8, d);
		#1 chk(fast_write_sel === s && write_rate === d[2:0], "write protocol");
		@(posedge mclk);
	endtask

	task automatic t_fields();
		rd32(8'ha8, 32'h0);
		wr32(8'hff, 32'hffffffff);
		rd32(8'hff, 32'h0);
		wr32(8'ha8, 32'hffffffff);
		rd32(8'ha8, 32'h00001f17);
		$display("fields test done");
	endtask

	task automatic t_gate();
		wr32(8'ha8, 32'h00001c00);
		op(3'h4, 3'h0);
		op(3'h2, 3'h0);
		op(3'h1, 3'h0);
		wr32(8'ha8, 32'h00001d00);
		op(3'h4, 3'h4);
		op(3'h1, 3'h1);
		op(3'h2, 3'h0);
		wr32(8'ha8, 32'h00001f01);
		op(3'h2, 3'h2);
		model.busy(1'b1);
		wr32(8'ha8, 32'h00001e01);
		op(3'h2, 3'h2);
		model.busy(1'b0);
		@(posedge mclk);
		op(3'h2, 3'h0);
		$display("gating test done");
	endtask

	task automatic t_fast();
		fw(32'h00001c11, 1'b0);
		fw(32'h00001c14, 1'b1);
		fw(32'h00001c04, 1'b0);
		$display("write protocol test done");
	endtask

	task automatic t_calib();
		int base;
		wr32(8'ha8, 32'h0);
		base = pulses;
		repeat (200) @(posedge mclk);
		chk(pulses - base >= 4 && pulses - base <= 5, "4 ms period");
		wr32(8'ha8, 32'h00001000);
		rd32(8'ha8, 32'h00001000);
		base = pulses;
		repeat (300) @(posedge mclk);
		chk(pulses == base, "reserved code period");
		wr32(8'ha8, 32'h00001c00);
		base = pulses;
		repeat (700) @(posedge mclk);
		chk(pulses == base, "calibration off");
		$display("calibration test done");
	endtask

	task automatic t_mode30();
		power_good <= 1'b0;
		vref_cmp_30 <= 1'b1;
		repeat (2) @(posedge mclk);
		power_good <= 1'b1;
		repeat (3) @(posedge mclk);
		#1 chk(mode_30 === 1'b1, "mode latch");
		@(posedge mclk);
		rd32(8'ha8, 32'h00000a00);
		wr32(8'ha8, 32'h00000900);
		op(3'h2, 3'h2);
		chk(sba_active === 1'b1, "sideband auto enable");
		fw(32'h00000911, 1'b1);
		$display("3.0 mode test done");
	endtask

	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		t_fields();
		t_gate();
		t_fast();
		t_calib();
		t_mode30();
		end_sim();
	end
endmodule
`default_nettype wire

// ---- verilog/calib_timer.v ----
// Periodic calibration cycle timer driven by the programmed period code
`include "gport_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module calib_timer #(
	parameter MS_CYCLES = `MS_NS / `CLK_NS
) (
	// Clock and reset
	input  wire       mclk,
	input  wire       rst_sync_n,
	// Period code
	input  wire [2:0] code,
	// Calibration start
	output reg        start
);

	reg [`MS_CNT_W-1:0] pre;
	reg [8:0]           ms_cnt;
	reg [2:0]           code_q;
	wire                ms_tick;
	wire [8:0]          period;

	// Reserved codes behave as the default period
	function [8:0] period_of;
		input [2:0] c;
		begin
			case (c)
			`CAL_4MS:   period_of = `PER_4MS;
			`CAL_16MS:  period_of = `PER_16MS;
			`CAL_256MS: period_of = `PER_256MS;
			default:    period_of = `PER_64MS;
			endcase
		end
	endfunction

	assign ms_tick = (pre == MS_CYCLES[`MS_CNT_W-1:0] - 1'b1);
	assign period  = period_of(code);

	// One millisecond enable; restarts when the code changes so a new period
	// starts from a clean count rather than finishing the old one
	always @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pre    <= {`MS_CNT_W{1'b0}};
			ms_cnt <= 9'h000;
			code_q <= 3'h0;
			start  <= 1'b0;
		end else begin
			code_q <= code;
			start  <= 1'b0;
			if (code != code_q || code == `CAL_NONE) begin
				pre    <= {`MS_CNT_W{1'b0}};
				ms_cnt <= 9'h000;
			end else if (ms_tick) begin
				pre <= {`MS_CNT_W{1'b0}};
				if (ms_cnt == period - 1'b1) begin
					ms_cnt <= 9'h000;
					start  <= 1'b1;
				end else begin
					ms_cnt <= ms_cnt + 1'b1;
				end
			end else begin
				pre <= pre + 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// ---- verilog/gport_consts.vh ----
// Constants for the graphics port command register block
//
// Function
// - Calibration period code in bits 12:10
// - Issue calibration cycles at programmed period
// - Code 111 stops all calibration cycles
// - Sideband enable bit ignored in 3.0 mode
// - 3.0 mode enables sideband addressing itself
// - Port disabled ignores every operation, sync too
// - Operations accepted while enabled finish fully
// - 1X sideband command in flight still issues
// - Enabled takes pipe ops, sideband needs enable
// - Above 4G enable reads zero, read-only
// - Fast write off or 1X uses PCI
// - Fast write on, not 1X, uses fast
// - Reset value depends on signaling mode
// - Mode latched at power good from comparator
`ifndef GPORT_CONSTS_VH
`define GPORT_CONSTS_VH

`define ADDR_W          8
`define CMD_OFFSET      8'ha8
`define STAT_OFFSET     8'hac

`define CAL_HI          12
`define CAL_LO          10
`define SBA_BIT         9
`define PEN_BIT         8
`define A4G_BIT         5
`define FWE_BIT         4
`define RATE_HI         2
`define RATE_LO         0

`define CMD_RESET_20    32'h00000000
`define CMD_RESET_30    32'h00000a00

`define CAL_4MS         3'h0
`define CAL_16MS        3'h1
`define CAL_64MS        3'h2
`define CAL_256MS       3'h3
`define CAL_NONE        3'h7

`define PER_4MS         9'h004
`define PER_16MS        9'h010
`define PER_64MS        9'h040
`define PER_256MS       9'h100

`define RATE_1X         3'h1

`define MS_NS           1000000
`define CLK_NS          10
`define MS_CNT_W        20

`define ST_MODE_BIT     0
`define ST_SBA_BIT      1
`define ST_FW_BIT       2
`define ST_CNT_HI       15
`define ST_CNT_LO       8

`endif

// ---- verilog/graphics_port_command_reg.v ----
// Graphics port command register with operation gating and calibration
`include "gport_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module graphics_port_command_reg #(
	parameter MS_CYCLES = `MS_NS / `CLK_NS
) (
	// Clock and reset
	input  wire                mclk,
	input  wire                rst_n,
	// Register port
	input  wire [`ADDR_W-1:0]  addr,
	input  wire [31:0]         wdata,
	input  wire                wr,
	input  wire                rd,
	output reg  [31:0]         rdata,
	// Signaling mode detection
	input  wire                power_good,
	input  wire                vref_cmp_30,
	output reg                 mode_30,
	// Operations from the graphics master
	input  wire                pipe_op_valid,
	input  wire                sba_op_valid,
	input  wire                sync_op_valid,
	input  wire                sba_1x_busy,
	output reg                 pipe_op_accept,
	output reg                 sba_op_accept,
	output reg                 sync_op_accept,
	// Sideband and write protocol state
	output reg                 sba_active,
	output reg                 fast_write_sel,
	output reg  [2:0]          write_rate,
	// Calibration cycle request
	output reg                 calib_cycle_start
);

	// Reset synchroniser
	reg rst_meta_n;
	reg rst_sync_n;

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// Register fields
	reg [2:0] calib_period_select;
	reg       sideband_addr_enable;
	reg       port_enable;
	reg       fast_write_enable;
	reg [2:0] data_rate;

	// Mode defaults as parameters so their fields can be selected
	localparam [31:0] DEF_20 = `CMD_RESET_20;
	localparam [31:0] DEF_30 = `CMD_RESET_30;

	// Mode tracking
	reg       init_pending;
	reg       pg_q;
	reg       next_mode;
	reg       mode_load;

	// Operation tracking
	reg       sba_hold;
	reg [7:0] calib_count;
	wire      calib_pulse;

	wire      cmd_hit;
	wire      stat_hit;
	wire      is_1x;
	wire      sba_ok;
	wire      pen_fall;

	assign cmd_hit  = (addr == `CMD_OFFSET);
	assign stat_hit = (addr == `STAT_OFFSET);

	// 1X exists only in the 2.0 signaling mode
	function is_rate_1x;
		input       m30;
		input [2:0] rate;
		begin
			is_rate_1x = !m30 && (rate == `RATE_1X);
		end
	endfunction

	// Effective sideband enable
	function sba_eff;
		input m30;
		input sbe;
		begin
			sba_eff = m30 | sbe;
		end
	endfunction

	assign is_1x    = is_rate_1x(mode_30, data_rate);
	assign sba_ok   = port_enable && sba_eff(mode_30, sideband_addr_enable);
	assign pen_fall = port_enable && wr && cmd_hit && !wdata[`PEN_BIT];

	// Mode is sampled at the first cycle after reset release when power good
	// is already up, and again on every rising edge of power good
	always @* begin
		next_mode = mode_30;
		mode_load = 1'b0;
		if (init_pending) begin
			mode_load = 1'b1;
			if (power_good)
				next_mode = vref_cmp_30;
		end else if (power_good && !pg_q) begin
			mode_load = 1'b1;
			next_mode = vref_cmp_30;
		end
	end

	always @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			init_pending <= 1'b1;
			pg_q         <= 1'b0;
			mode_30      <= 1'b0;
		end else begin
			init_pending <= 1'b0;
			pg_q         <= power_good;
			mode_30      <= next_mode;
		end
	end

	// Command register fields; a mode load applies the mode's default value,
	// which wins over a write in the same cycle
	always @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			calib_period_select  <= DEF_20[`CAL_HI:`CAL_LO];
			sideband_addr_enable <= DEF_20[`SBA_BIT];
			port_enable          <= DEF_20[`PEN_BIT];
			fast_write_enable    <= DEF_20[`FWE_BIT];
			data_rate            <= DEF_20[`RATE_HI:`RATE_LO];
		end else if (mode_load) begin
			if (next_mode) begin
				calib_period_select  <= DEF_30[`CAL_HI:`CAL_LO];
				sideband_addr_enable <= DEF_30[`SBA_BIT];
				port_enable          <= DEF_30[`PEN_BIT];
				fast_write_enable    <= DEF_30[`FWE_BIT];
				data_rate            <= DEF_30[`RATE_HI:`RATE_LO];
			end else begin
				calib_period_select  <= DEF_20[`CAL_HI:`CAL_LO];
				sideband_addr_enable <= DEF_20[`SBA_BIT];
				port_enable          <= DEF_20[`PEN_BIT];
				fast_write_enable    <= DEF_20[`FWE_BIT];
				data_rate            <= DEF_20[`RATE_HI:`RATE_LO];
			end
		end else if (wr && cmd_hit) begin
			// Reserved codes are stored as written
			calib_period_select  <= wdata[`CAL_HI:`CAL_LO];
			sideband_addr_enable <= wdata[`SBA_BIT];
			port_enable          <= wdata[`PEN_BIT];
			fast_write_enable    <= wdata[`FWE_BIT];
			data_rate            <= wdata[`RATE_HI:`RATE_LO];
		end
	end

	// A 1X sideband command already under way when the port is disabled is
	// still taken; the hold ends when that command arrives or delivery stops
	always @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sba_hold <= 1'b0;
		end else if (sba_op_valid || !sba_1x_busy) begin
			sba_hold <= 1'b0;
		end else if (sba_1x_busy && sba_ok && is_1x && pen_fall) begin
			sba_hold <= 1'b1;
		end
	end

	// Acceptance of operations; once accepted, the accept pulse is passed on
	// and is never withdrawn by a later clear of the enable
	always @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pipe_op_accept <= 1'b0;
			sba_op_accept  <= 1'b0;
			sync_op_accept <= 1'b0;
		end else begin
			pipe_op_accept <= pipe_op_valid && port_enable;
			sync_op_accept <= sync_op_valid && port_enable;
			sba_op_accept  <= sba_op_valid && (sba_ok || sba_hold);
		end
	end

	// Sideband path and write protocol selection
	always @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sba_active     <= 1'b0;
			fast_write_sel <= 1'b0;
			write_rate     <= 3'h0;
		end else begin
			sba_active     <= sba_eff(mode_30, sideband_addr_enable);
			fast_write_sel <= fast_write_enable && !is_1x;
			write_rate     <= data_rate;
		end
	end

	// Calibration timer
	calib_timer #(
		.MS_CYCLES (MS_CYCLES)
	) u_calib_timer (
		.mclk       (mclk),
		.rst_sync_n (rst_sync_n),
		.code       (calib_period_select),
		.start      (calib_pulse)
	);

	always @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			calib_cycle_start <= 1'b0;
			calib_count       <= 8'h00;
		end else begin
			calib_cycle_start <= calib_pulse;
			if (calib_pulse)
				calib_count <= calib_count + 1'b1;
		end
	end

	// Register reads; unmapped addresses return zero
	always @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rdata <= 32'h00000000;
		end else if (rd && cmd_hit) begin
			rdata                    <= 32'h00000000;
			rdata[`CAL_HI:`CAL_LO]   <= calib_period_select;
			rdata[`SBA_BIT]          <= sideband_addr_enable;
			rdata[`PEN_BIT]          <= port_enable;
			rdata[`A4G_BIT]          <= 1'b0;
			rdata[`FWE_BIT]          <= fast_write_enable;
			rdata[`RATE_HI:`RATE_LO] <= data_rate;
		end else if (rd && stat_hit) begin
			rdata                      <= 32'h00000000;
			rdata[`ST_MODE_BIT]        <= mode_30;
			rdata[`ST_SBA_BIT]         <= sba_active;
			rdata[`ST_FW_BIT]          <= fast_write_sel;
			rdata[`ST_CNT_HI:`ST_CNT_LO] <= calib_count;
		end else begin
			rdata <= 32'h00000000;
		end
	end

endmodule
`default_nettype wire
